// >>> rtl/brca_consts.svh
// constants of the bridge command and result access block
`ifndef BRCA_CONSTS_SVH
`define BRCA_CONSTS_SVH

// command codes, first data byte after the write address
`define BRCA_CMD_READ_BYTE    8'h96
`define BRCA_CMD_SINGLE_SLOT  8'h87
`define BRCA_CMD_SEARCH_TRIPLE 8'h78
`define BRCA_CMD_POINTER      8'he1

// pointer codes
`define BRCA_PTR_READ_DATA    8'he1
`define BRCA_PTR_STATUS       8'hf0

// status byte field positions
`define BRCA_STS_BUSY         0
`define BRCA_STS_SLOT_BIT     5
`define BRCA_STS_SECOND_BIT   6
`define BRCA_STS_DIRECTION    7

// status reset value
`define BRCA_STS_RESET        8'h00

// clock period and line slot times in ns
`define BRCA_CLK_NS           20
`define BRCA_T_LOW_ONE_NS     6000
`define BRCA_T_LOW_ZERO_NS    60000
`define BRCA_T_SAMPLE_NS      15000
`define BRCA_T_SLOT_NS        80000

// slot times as clock counts: lows round up, sample point rounds down
`define BRCA_N_LOW_ONE  ((`BRCA_T_LOW_ONE_NS + `BRCA_CLK_NS - 1) / `BRCA_CLK_NS)
`define BRCA_N_LOW_ZERO ((`BRCA_T_LOW_ZERO_NS + `BRCA_CLK_NS - 1) / `BRCA_CLK_NS)
`define BRCA_N_SAMPLE   (`BRCA_T_SAMPLE_NS / `BRCA_CLK_NS)
`define BRCA_N_SLOT     ((`BRCA_T_SLOT_NS + `BRCA_CLK_NS - 1) / `BRCA_CLK_NS)

`endif

// >>> rtl/brca_pkg.sv
// types of the bridge command and result access block
package brca_pkg;

	// serial port states
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_ADDR = 5'b00010,
		S_WR   = 5'b00100,
		S_RD   = 5'b01000,
		S_WAIT = 5'b10000
	} brca_port_st_t;

	// what the next written byte means
	typedef enum logic [3:0] {
		X_CMD  = 4'b0001,
		X_PTR  = 4'b0010,
		X_PRM  = 4'b0100,
		X_DONE = 4'b1000
	} brca_expect_t;

	// line engine states
	typedef enum logic [2:0] {
		E_IDLE = 3'b001,
		E_SLOT = 3'b010,
		E_PUSH = 3'b100
	} brca_eng_st_t;

	// line operations
	typedef enum logic [2:0] {
		OP_READ_BYTE = 3'b001,
		OP_SINGLE    = 3'b010,
		OP_TRIPLE    = 3'b100
	} brca_op_t;

endpackage

// >>> rtl/brca_fifo.sv
// small first-in first-out buffer with registered read data
`timescale 1ns/1ns
module brca_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr_q, wptr_d;
	logic [AW-1:0]    rptr_q, rptr_d;
	logic [AW:0]      count_q, count_d;
	logic [WIDTH-1:0] head_q, head_d;
	logic             push;
	logic             pop;

	// honest full and empty
	assign in_ready  = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data  = head_q;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointers, count and registered head word
	always_comb begin
		wptr_d  = push ? wptr_q + AW'(1) : wptr_q;
		rptr_d  = pop ? rptr_q + AW'(1) : rptr_q;
		count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
		head_d  = head_q;
		if (push && (count_q == '0 || (pop && count_q == (AW+1)'(1)))) begin
			head_d = in_data; // head bypass when buffer runs dry
		end else if (pop) begin
			head_d = mem[rptr_q + AW'(1)];
		end
	end

	// state registers
	always_ff @(posedge clk) begin
		if (rst) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
			head_q  <= '0;
		end else begin
			wptr_q  <= wptr_d;
			rptr_q  <= rptr_d;
			count_q <= count_d;
			head_q  <= head_d;
		end
	end

	// storage array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_q] <= in_data;
		end
	end
endmodule // brca_fifo

// >>> rtl/brca_top.sv
// serial slave port, command interpreter and single-wire line engine
`timescale 1ns/1ns
`include "brca_consts.svh"
module brca_top
	import brca_pkg::*;
#(
	parameter logic [6:0] I2C_ADDR   = 7'h2a, // arbitrary slave address
	parameter int         FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic CLK,
	input  wire logic RST,
	// serial host port
	input  wire logic SCL_I,
	input  wire logic SDA_I,
	output logic      SDA_O,
	output logic      SDA_OE,
	// single-wire line
	input  wire logic LINE_I,
	output logic      LINE_O,
	output logic      LINE_OE,
	// status
	output logic      LINE_BUSY
);
	localparam logic [11:0] N_LOW_ONE  = 12'(`BRCA_N_LOW_ONE);
	localparam logic [11:0] N_LOW_ZERO = 12'(`BRCA_N_LOW_ZERO);
	localparam logic [11:0] N_SAMPLE   = 12'(`BRCA_N_SAMPLE);
	localparam logic [11:0] N_SLOT     = 12'(`BRCA_N_SLOT);

	// line command codes that the busy flag blocks
	function automatic logic is_line_cmd(input logic [7:0] b);
		is_line_cmd = (b == `BRCA_CMD_READ_BYTE) || (b == `BRCA_CMD_SINGLE_SLOT) ||
			(b == `BRCA_CMD_SEARCH_TRIPLE);
	endfunction

	// pin synchronisers
	logic scl_m, scl_s, scl_p;
	logic sda_m, sda_s, sda_p;
	logic line_m, line_s;

	// serial port state
	brca_port_st_t st_q, st_d;
	brca_expect_t  exp_q, exp_d;
	logic [3:0]    cnt_q, cnt_d;
	logic [7:0]    sh_q, sh_d;
	logic [7:0]    tx_q, tx_d;
	logic          oe_q, oe_d;
	logic          rw_q, rw_d;
	logic          nack_q, nack_d;
	logic          ptr_data_q, ptr_data_d;
	logic [7:0]    rdata_q, rdata_d;
	brca_op_t      pend_q, pend_d;

	// handshakes between port and engine
	logic          go;
	brca_op_t      go_op;
	logic          go_prm;
	logic          pop;

	// engine state
	brca_eng_st_t  eng_q, eng_d;
	brca_op_t      op_q, op_d;
	logic [11:0]   tc_q, tc_d;
	logic [1:0]    sidx_q, sidx_d;
	logic [2:0]    bidx_q, bidx_d;
	logic          wbit_q, wbit_d;
	logic          prm_q, prm_d;
	logic          low_q, low_d;
	logic [7:0]    rbyte_q, rbyte_d;
	logic          sbr_q, sbr_d;
	logic          tsb_q, tsb_d;
	logic          dir_q, dir_d;

	// buffer wires
	logic          fifo_in_ready;
	logic          fifo_out_valid;
	logic [7:0]    fifo_out_data;
	logic          busy;

	// edge and condition detection on synchronised pins
	logic scl_rise, scl_fall, start_c, stop_c;
	logic [7:0] status_byte;
	logic [7:0] load_byte;
	logic       ack;

	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;
	assign busy     = (eng_q != E_IDLE);

	// outputs: open-drain data, clock never driven
	assign SDA_O     = 1'b0;
	assign SDA_OE    = oe_q;
	assign LINE_O    = 1'b0;
	assign LINE_OE   = low_q;
	assign LINE_BUSY = busy;

	// status byte built from engine state
	always_comb begin
		status_byte                         = `BRCA_STS_RESET;
		status_byte[`BRCA_STS_BUSY]         = busy;
		status_byte[`BRCA_STS_SLOT_BIT]     = sbr_q;
		status_byte[`BRCA_STS_SECOND_BIT]   = tsb_q;
		status_byte[`BRCA_STS_DIRECTION]    = dir_q;
	end

	// read data: buffered byte first, else the last one fetched
	always_comb begin
		if (!ptr_data_q) begin
			load_byte = status_byte;
		end else if (fifo_out_valid) begin
			load_byte = fifo_out_data;
		end else begin
			load_byte = rdata_q;
		end
	end

	// two flip-flops on every pin before any logic
	always_ff @(posedge CLK) begin
		if (RST) begin
			scl_m  <= 1'b1;
			scl_s  <= 1'b1;
			scl_p  <= 1'b1;
			sda_m  <= 1'b1;
			sda_s  <= 1'b1;
			sda_p  <= 1'b1;
			line_m <= 1'b1;
			line_s <= 1'b1;
		end else begin
			scl_m  <= SCL_I;
			scl_s  <= scl_m;
			scl_p  <= scl_s;
			sda_m  <= SDA_I;
			sda_s  <= sda_m;
			sda_p  <= sda_s;
			line_m <= LINE_I;
			line_s <= line_m;
		end
	end

	// serial port and command decode next state
	always_comb begin
		st_d       = st_q;
		exp_d      = exp_q;
		cnt_d      = cnt_q;
		sh_d       = sh_q;
		tx_d       = tx_q;
		oe_d       = oe_q;
		rw_d       = rw_q;
		nack_d     = nack_q;
		ptr_data_d = ptr_data_q;
		rdata_d    = rdata_q;
		pend_d     = pend_q;
		go         = 1'b0;
		go_op      = pend_q;
		go_prm     = 1'b0;
		pop        = 1'b0;
		ack        = 1'b0;
		if (stop_c) begin
			st_d = S_IDLE;
			oe_d = 1'b0;
		end else if (start_c) begin
			st_d  = S_ADDR;
			exp_d = X_CMD;
			cnt_d = 4'd0;
			oe_d  = 1'b0;
		end else if (st_q != S_IDLE && st_q != S_WAIT) begin
			if (scl_rise) begin
				if (cnt_q < 4'd8) begin
					sh_d = {sh_q[6:0], sda_s};
				end else if (st_q == S_RD) begin
					nack_d = sda_s; // master acknowledge bit
				end
				cnt_d = cnt_q + 4'd1;
			end else if (scl_fall) begin
				if (cnt_q == 4'd8) begin
					unique case (st_q)
						S_ADDR: begin
							ack  = (sh_q[7:1] == I2C_ADDR);
							rw_d = sh_q[0];
						end
						S_WR: begin
							unique case (exp_q)
								X_CMD: begin
									if (sh_q == `BRCA_CMD_POINTER) begin
										ack   = 1'b1;
										exp_d = X_PTR;
									end else if (is_line_cmd(sh_q) && busy) begin
										ack   = 1'b0;
									end else if (sh_q == `BRCA_CMD_READ_BYTE) begin
										ack        = fifo_in_ready;
										go         = fifo_in_ready;
										go_op      = OP_READ_BYTE;
										ptr_data_d = fifo_in_ready ? 1'b0 : ptr_data_q;
										exp_d      = X_DONE;
									end else if (sh_q == `BRCA_CMD_SINGLE_SLOT) begin
										ack    = 1'b1;
										pend_d = OP_SINGLE;
										exp_d  = X_PRM;
									end else if (sh_q == `BRCA_CMD_SEARCH_TRIPLE) begin
										ack    = 1'b1;
										pend_d = OP_TRIPLE;
										exp_d  = X_PRM;
									end
								end
								X_PTR: begin
									ack = (sh_q == `BRCA_PTR_READ_DATA) ||
										(sh_q == `BRCA_PTR_STATUS);
									if (ack) begin
										ptr_data_d = (sh_q == `BRCA_PTR_READ_DATA);
									end
									exp_d = X_DONE;
								end
								X_PRM: begin
									ack        = 1'b1;
									go         = 1'b1;
									go_prm     = sh_q[7];
									ptr_data_d = 1'b0;
									exp_d      = X_DONE;
								end
								X_DONE: ack = 1'b0;
							endcase
						end
						S_RD: ack = 1'b0; // release for master acknowledge
						default: ack = 1'b0;
					endcase
					oe_d = ack;
					if (st_q != S_RD && !ack) begin
						st_d = S_WAIT; // refused, wait for stop or start
					end
				end else if (cnt_q == 4'd9) begin
					cnt_d = 4'd0;
					oe_d  = 1'b0;
					if (st_q == S_ADDR) begin
						st_d = rw_q ? S_RD : S_WR;
					end else if (st_q == S_RD && nack_q) begin
						st_d = S_WAIT;
					end
					if ((st_q == S_ADDR && rw_q) || (st_q == S_RD && !nack_q)) begin
						tx_d = load_byte;
						oe_d = ~load_byte[7];
						if (ptr_data_q && fifo_out_valid) begin
							pop     = 1'b1;
							rdata_d = fifo_out_data;
						end
					end
				end else if (st_q == S_RD && cnt_q != 4'd0) begin
					oe_d = ~tx_q[3'd7 - cnt_q[2:0]];
				end
			end
		end
	end

	// serial port registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_q       <= S_IDLE;
			exp_q      <= X_CMD;
			cnt_q      <= 4'd0;
			sh_q       <= 8'h00;
			tx_q       <= 8'h00;
			oe_q       <= 1'b0;
			rw_q       <= 1'b0;
			nack_q     <= 1'b0;
			ptr_data_q <= 1'b0;
			rdata_q    <= 8'h00;
			pend_q     <= OP_SINGLE;
		end else begin
			st_q       <= st_d;
			exp_q      <= exp_d;
			cnt_q      <= cnt_d;
			sh_q       <= sh_d;
			tx_q       <= tx_d;
			oe_q       <= oe_d;
			rw_q       <= rw_d;
			nack_q     <= nack_d;
			ptr_data_q <= ptr_data_d;
			rdata_q    <= rdata_d;
			pend_q     <= pend_d;
		end
	end

	// line engine next state: slots of fixed length
	always_comb begin
		eng_d   = eng_q;
		op_d    = op_q;
		tc_d    = tc_q;
		sidx_d  = sidx_q;
		bidx_d  = bidx_q;
		wbit_d  = wbit_q;
		prm_d   = prm_q;
		rbyte_d = rbyte_q;
		sbr_d   = sbr_q;
		tsb_d   = tsb_q;
		dir_d   = dir_q;
		low_d   = 1'b0;
		unique case (eng_q)
			E_IDLE: begin
				if (go) begin
					eng_d  = E_SLOT;
					op_d   = go_op;
					prm_d  = go_prm;
					tc_d   = 12'd0;
					sidx_d = 2'd0;
					bidx_d = 3'd0;
					wbit_d = (go_op == OP_SINGLE) ? go_prm : 1'b1;
				end
			end
			E_SLOT: begin
				tc_d  = tc_q + 12'd1;
				low_d = (tc_q < (wbit_q ? N_LOW_ONE : N_LOW_ZERO)); // full count of low cycles
				if (tc_q == N_SAMPLE) begin
					unique case (op_q)
						OP_READ_BYTE: rbyte_d = {line_s, rbyte_q[7:1]};
						OP_SINGLE:    sbr_d   = line_s;
						OP_TRIPLE: begin
							if (sidx_q == 2'd0) begin
								sbr_d = line_s;
							end else if (sidx_q == 2'd1) begin
								tsb_d = line_s;
							end
						end
					endcase
				end
				if (tc_q == N_SLOT - 12'd1) begin
					tc_d   = 12'd0;
					low_d  = 1'b0;
					sidx_d = sidx_q + 2'd1;
					bidx_d = bidx_q + 3'd1;
					unique case (op_q)
						OP_READ_BYTE: eng_d = (bidx_q == 3'd7) ? E_PUSH : E_SLOT;
						OP_SINGLE:    eng_d = E_IDLE;
						OP_TRIPLE: begin
							if (sidx_q == 2'd1) begin
								// both bits alike: take the given direction, or one if no answer
								dir_d  = (sbr_q ^ tsb_q) ? sbr_q : (sbr_q | prm_q);
								wbit_d = (sbr_q ^ tsb_q) ? sbr_q : (sbr_q | prm_q);
							end else if (sidx_q == 2'd2) begin
								eng_d = E_IDLE;
							end
						end
					endcase
				end
			end
			E_PUSH: begin
				if (fifo_in_ready) begin
					eng_d = E_IDLE; // busy holds until the byte is stored
				end
			end
			default: eng_d = E_IDLE;
		endcase
	end

	// line engine registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			eng_q   <= E_IDLE;
			op_q    <= OP_SINGLE;
			tc_q    <= 12'd0;
			sidx_q  <= 2'd0;
			bidx_q  <= 3'd0;
			wbit_q  <= 1'b1;
			prm_q   <= 1'b0;
			low_q   <= 1'b0;
			rbyte_q <= 8'h00;
			sbr_q   <= 1'b0;
			tsb_q   <= 1'b0;
			dir_q   <= 1'b0;
		end else begin
			eng_q   <= eng_d;
			op_q    <= op_d;
			tc_q    <= tc_d;
			sidx_q  <= sidx_d;
			bidx_q  <= bidx_d;
			wbit_q  <= wbit_d;
			prm_q   <= prm_d;
			low_q   <= low_d;
			rbyte_q <= rbyte_d;
			sbr_q   <= sbr_d;
			tsb_q   <= tsb_d;
			dir_q   <= dir_d;
		end
	end

	// received bytes wait here until the host reads them
	brca_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst       (RST),
		.in_valid  (eng_q == E_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   (rbyte_q),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (fifo_out_data)
	);
endmodule // brca_top

// >>> dv/brca_top_checker.sv
// port assertions of the bridge command and result access block
`timescale 1ns/1ns
module brca_top_checker #(
	parameter logic [6:0] I2C_ADDR   = 7'h2a,
	parameter int         FIFO_DEPTH = 16
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// serial host port
	input wire logic SCL_I,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE,
	// single-wire line
	input wire logic LINE_I,
	input wire logic LINE_O,
	input wire logic LINE_OE,
	input wire logic LINE_BUSY
);
	logic [11:0] oe_cnt_q;
	logic [11:0] oe_cnt_d;

	// cycles the line has been held low so far
	always_comb oe_cnt_d = LINE_OE ? oe_cnt_q + 12'h001 : 12'h000;
	always_ff @(posedge CLK) oe_cnt_q <= RST ? 12'h000 : oe_cnt_d;

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	a_reset_quiet: assert property (disable iff (1'b0) RST |=> !SDA_OE && !LINE_OE && !LINE_BUSY)
		else $error("outputs active right after reset");
	a_open_drain_only: assert property (SDA_O == 1'b0 && LINE_O == 1'b0)
		else $error("open-drain pin driven high");
	a_sda_clock_low: assert property ($changed(SDA_OE) |-> !SCL_I)
		else $error("serial data changed while clock high");
	a_sda_bounded: assert property (SDA_OE |-> ##[1:300] !SDA_OE)
		else $error("serial data held low too long");
	a_idle_no_drive: assert property (!LINE_BUSY |-> !LINE_OE)
		else $error("line driven while not busy");
	a_busy_starts_slot: assert property ($rose(LINE_BUSY) |-> ##[0:8] LINE_OE)
		else $error("busy without a slot starting");
	a_slot_width: assert property ($fell(LINE_OE) |-> oe_cnt_q == 12'h12c || oe_cnt_q == 12'hbb8)
		else $error("line low time not 300 or 3000 cycles");
	a_busy_tail: assert property ($fell(LINE_BUSY) |-> !$past(LINE_OE, 200))
		else $error("busy fell before slot recovery ended");

	// main scenarios reached
	c_op_done: cover property ($fell(LINE_BUSY));
	c_long_low: cover property ($fell(LINE_OE) && oe_cnt_q == 12'hbb8);
	c_ack: cover property ($rose(SDA_OE));
endmodule // brca_top_checker

bind brca_top brca_top_checker #(.I2C_ADDR(I2C_ADDR), .FIFO_DEPTH(FIFO_DEPTH)) brca_top_checker_inst (
	.CLK(CLK), .RST(RST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
	.LINE_I(LINE_I), .LINE_O(LINE_O), .LINE_OE(LINE_OE), .LINE_BUSY(LINE_BUSY));

// >>> dv/brca_line_model.sv
// behavioural single-wire slave answering slots from a pull pattern
`timescale 1ns/1ns
module brca_line_model (
	// line level and pattern
	input wire logic        line,
	input wire logic [15:0] pat,
	input wire logic        load,
	// pull toward low
	output logic            pull
);
	int idx;

	initial begin
		pull = 1'b0;
		idx = 0;
	end
	// restart the pattern for each scenario
	always @(posedge load) idx = 0;
	// hold a slot low past the sample point when the pattern asks for a zero
	always @(negedge line) begin
		if (pat[idx[3:0]]) begin
			pull = 1'b1;
			#30000 pull = 1'b0;
		end
		idx++;
	end
endmodule // brca_line_model

// >>> dv/testbench.sv
// self-checking bench of the bridge command and result access block
`timescale 1ns/1ns
`include "brca_consts.svh"
module testbench;
	localparam logic [6:0] ADDR = 7'h2a; // arbitrary slave address
	logic        CLK, RST, scl, sda_h, sda_o, sda_oe, line_o, line_oe, busy, pull, load;
	logic [15:0] pat;
	int          failures, checks_done, slots;
	wire         sda_w  = sda_h & ~sda_oe;
	wire         line_w = ~(line_oe | pull);

	brca_top #(.I2C_ADDR(ADDR)) brca_top_inst (.CLK(CLK), .RST(RST), .SCL_I(scl),
		.SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe), .LINE_I(line_w), .LINE_O(line_o),
		.LINE_OE(line_oe), .LINE_BUSY(busy));
	brca_line_model brca_line_model_inst (.line(line_w), .pat(pat), .load(load), .pull(pull));

	// clock and slot counter
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	always @(posedge line_oe) slots++;

	task cyc(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one serial bit, phases of 8 cycles
	task bitx(input logic b, output logic r);
		cyc(2);
		sda_h = b;
		cyc(8);
		scl = 1'b1;
		cyc(8);
		r = sda_w;
		scl = 1'b0;
	endtask
	task start;
		cyc(2);
		sda_h = 1'b1;
		cyc(8);
		scl = 1'b1;
		cyc(8);
		sda_h = 1'b0;
		cyc(8);
		scl = 1'b0;
	endtask
	task stop;
		cyc(2);
		sda_h = 1'b0;
		cyc(8);
		scl = 1'b1;
		cyc(8);
		sda_h = 1'b1;
		cyc(8);
	endtask
	task wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	// write transfer, parameter byte sent only when the command byte is acknowledged
	task wr(input logic [7:0] c, input logic [7:0] p, input int n, output logic ok);
		logic a0, a1, a2;
		start;
		wbyte({ADDR, 1'b0}, a0);
		wbyte(c, a1);
		a2 = 1'b1;
		if (n > 1 && a1) wbyte(p, a2);
		stop;
		ok = a0 & a1 & a2;
	endtask
	// plain read of one byte, host refuses after it
	task rd(output logic [7:0] d);
		logic a, r;
		start;
		wbyte({ADDR, 1'b1}, a);
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(1'b1, r);
		stop;
	endtask
	task arm(input logic [15:0] p);
		pat = p;
		load = 1'b1;
		cyc(1);
		load = 1'b0;
		slots = 0;
	endtask

	// byte read with the pointer moved early, line commands refused while busy
	task t_read_byte;
		logic       ok;
		logic [7:0] d;
		logic [7:0] codes [3];
		int         k;
		codes = '{`BRCA_CMD_READ_BYTE, `BRCA_CMD_SINGLE_SLOT, `BRCA_CMD_SEARCH_TRIPLE};
		arm(16'h005a);
		wr(`BRCA_CMD_READ_BYTE, 8'h00, 1, ok);
		cmp("read cmd ack", 8'h01, {7'h00, ok});
		foreach (codes[i]) begin
			wr(codes[i], 8'h80, 2, ok);
			cmp("busy refusal", 8'h00, {7'h00, ok});
		end
		wr(`BRCA_CMD_POINTER, `BRCA_PTR_READ_DATA, 2, ok);
		cmp("early pointer ack", 8'h01, {7'h00, ok});
		k = 0;
		while (busy !== 1'b0 && k < 40000) begin
			cyc(1);
			k++;
		end
		if (k >= 40000) failures++;
		rd(d);
		cmp("line byte", 8'ha5, d);
		wr(`BRCA_CMD_POINTER, 8'he5, 2, ok);
		cmp("bad pointer refusal", 8'h00, {7'h00, ok});
		wr(`BRCA_CMD_POINTER, `BRCA_PTR_STATUS, 2, ok);
		cmp("status pointer ack", 8'h01, {7'h00, ok});
		rd(d);
		cmp("idle status", 8'h00, d);
	endtask

	// single slot with polling through the status pointer
	task t_single;
		logic       ok;
		logic [7:0] s;
		int         k;
		arm(16'h0000);
		wr(`BRCA_CMD_SINGLE_SLOT, 8'h80, 2, ok);
		cmp("slot cmd ack", 8'h01, {7'h00, ok});
		rd(s);
		cmp("busy while slot", 8'h01, {7'h00, s[0]});
		k = 0;
		while (s[0] !== 1'b0 && k < 100) begin
			rd(s);
			k++;
		end
		if (k >= 100) failures++;
		cmp("slot status", 8'h20, s);
		cmp("slot count", 8'h01, slots[7:0]);
	endtask

	// triplets with differing and equal read bits, result after fixed idle
	task t_triplet;
		logic        ok;
		logic [7:0]  s;
		logic [7:0]  exp [2];
		logic [7:0]  prm [2];
		logic [15:0] pats [2];
		exp = '{8'h40, 8'he0};
		prm = '{8'h80, 8'h00};
		pats = '{16'h0001, 16'h0000};
		for (int i = 0; i < 2; i++) begin
			arm(pats[i]);
			wr(`BRCA_CMD_SEARCH_TRIPLE, prm[i], 2, ok);
			cmp("triplet cmd ack", 8'h01, {7'h00, ok});
			cyc(12500);
			rd(s);
			cmp("triplet status", exp[i], s);
			cmp("triplet slots", 8'h03, slots[7:0]);
		end
	endtask

	task finish_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// watchdog
	initial begin
		cyc(100000);
		failures++;
		finish_test;
	end
	// main sequence
	initial begin
		RST = 1'b1;
		scl = 1'b1;
		sda_h = 1'b1;
		pat = 16'h0000;
		load = 1'b0;
		failures = 0;
		checks_done = 0;
		slots = 0;
		cyc(12);
		RST = 1'b0;
		cyc(4);
		t_read_byte;
		t_single;
		t_triplet;
		finish_test;
	end
endmodule // testbench
